// ===== core/lpm_pkg.sv
`default_nettype none
package lpm_pkg;
  localparam int unsigned AXI_AW = 8;
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Control register fields.
  localparam int unsigned C_OSC = 0;
  localparam int unsigned C_STOPEN = 1;
  localparam int unsigned C_BCS = 2;
  localparam int unsigned C_PLL_POWER_ON = 3;
  localparam int unsigned C_CH_LO = 4;
  localparam int unsigned CH_W = 5;
  localparam logic [CH_W-1:0] CH_RESET = 5'h00;
  localparam logic [CH_W-1:0] CH_POWER_DOWN = 5'h1f;
  // Status register fields.
  localparam int unsigned S_MODE_LO = 0;
  localparam int unsigned S_BW = 4;
  localparam int unsigned S_IMASK = 5;
  localparam int unsigned S_IDX_LO = 8;
  // Vector table: slot index i sits at VEC_BASE + 2*i, high byte first.
  localparam logic [15:0] VEC_BASE = 16'hffdc;
  localparam int unsigned SLOTS = 18;
  localparam int unsigned IDX_W = 5;
  localparam logic [IDX_W-1:0] IDX_TB = 5'h00;
  localparam logic [IDX_W-1:0] IDX_KBD = 5'h02;
  localparam logic [IDX_W-1:0] IDX_RSVD = 5'h09;
  localparam logic [IDX_W-1:0] IDX_EXT = 5'h0f;
  localparam logic [IDX_W-1:0] IDX_SWI = 5'h10;
  localparam logic [IDX_W-1:0] IDX_RESET = 5'h11;
  localparam int unsigned REC_W = 12;
  localparam int unsigned DIV_W = 8;
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_WAIT = 4'h2,
    ST_STOP = 4'h4,
    ST_RECOV = 4'h8
  } lpm_state_e;
  typedef struct packed {
    logic cpu_clk_en;
    logic bus_clk_en;
    logic crystal_clock_en;
    logic osc_enable;
    logic pll_enable;
    logic bus_clock_output_en;
    logic clock_gen_interrupt_en;
    logic adc_enable;
    logic brk_active;
    logic cop_clk_en;
  } lpm_gates_s;
endpackage : lpm_pkg
`default_nettype wire

// ===== core/lpm_ctrl.sv
`default_nettype none
module lpm_ctrl #(
  parameter int unsigned XTAL_DIV = 4,
  parameter int unsigned RECOVERY_TICKS = 4096
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave.
  input wire logic [lpm_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [lpm_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Processor core and peripheral requests.
  input wire logic wait_instr,
  input wire logic stop_instr,
  input wire logic reset_req,
  input wire logic brk_req,
  input wire logic [lpm_pkg::SLOTS-1:0] irq_req,
  // Clock gates and peripheral controls.
  output lpm_pkg::lpm_gates_s gates,
  output logic adc_abort,
  output logic cop_presc_clr,
  // Wake results towards the core.
  output logic i_mask,
  output logic [15:0] vector_addr,
  output logic vector_valid
);
  import lpm_pkg::*;

  lpm_state_e st_r, st_nxt;
  logic osc_stop_en_r, stop_en_r, bcs_r, pll_power_on_r;
  logic [CH_W-1:0] ch_sel_r;
  logic bw_r;
  logic [IDX_W-1:0] idx_r, wake_idx;
  logic [REC_W-1:0] rec_cnt_r;
  logic [DIV_W-1:0] div_r;
  logic xtick;
  logic wait_wake, stop_wake, stop_go, rec_done;
  logic aw_rdy_r, w_rdy_r, ar_rdy_r;
  logic [AXI_AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;

  // Picks the highest-priority pending source; later slots outrank earlier.
  function automatic logic [IDX_W-1:0] top_src(
    input logic [SLOTS-1:0] req, input logic break_unit);
    logic [IDX_W-1:0] r;
    r = IDX_TB;
    for (int i = 0; i < SLOTS; i++) begin
      if (req[i] && (IDX_W'(i) != IDX_RSVD)) begin
        r = IDX_W'(i);
      end
    end
    if (break_unit) begin
      r = IDX_SWI;
    end
    return r;
  endfunction : top_src

  // Vector address of a slot, high byte at the even address.
  function automatic logic [15:0] vec_of(input logic [IDX_W-1:0] idx);
    return VEC_BASE + {10'h000, idx, 1'b0};
  endfunction : vec_of

  // Wake qualification; stop only hears external, keyboard, break, timer-base with osc.
  always_comb begin
    wait_wake = brk_req;
    stop_wake = brk_req | irq_req[IDX_EXT] | irq_req[IDX_KBD]
              | (irq_req[IDX_TB] & osc_stop_en_r);
    for (int i = 0; i < SLOTS; i++) begin
      if (IDX_W'(i) != IDX_RSVD) begin
        wait_wake = wait_wake | irq_req[i];
      end
    end
    wake_idx = top_src(irq_req, brk_req);
  end

  assign stop_go = stop_instr & stop_en_r;
  assign rec_done = xtick && (rec_cnt_r == REC_W'(RECOVERY_TICKS - 1));

  // Mode sequencer; an ignored stop leaves the core running.
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_RUN: begin
        if (wait_instr) begin
          st_nxt = ST_WAIT;
        end else if (stop_go) begin
          st_nxt = ST_STOP;
        end
      end
      ST_WAIT: begin
        if (reset_req || wait_wake) begin
          st_nxt = ST_RUN;
        end
      end
      ST_STOP: begin
        if (reset_req || stop_wake) begin
          st_nxt = ST_RECOV;
        end
      end
      ST_RECOV: begin
        if (rec_done) begin
          st_nxt = ST_RUN;
        end
      end
      default: st_nxt = ST_RUN;
    endcase
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_RUN;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Crystal-rate enable for the recovery count only. It restarts in stop,
  // so a wake never lands mid-tick and shortens the recovery delay.
  always_ff @(posedge aclk) begin
    if (!aresetn || st_r == ST_STOP) begin
      div_r <= '0;
    end else if (div_r == DIV_W'(XTAL_DIV - 1)) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end
  assign xtick = (div_r == DIV_W'(XTAL_DIV - 1));

  // Stop recovery counter; restarts for each wake so the delay is full.
  always_ff @(posedge aclk) begin
    if (!aresetn || st_r != ST_RECOV) begin
      rec_cnt_r <= '0;
    end else if (xtick) begin
      rec_cnt_r <= rec_cnt_r + 12'h001;
    end
  end

  // Wake source latch, taken when leaving wait or stop.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_r <= IDX_RESET;
    end else if ((st_r == ST_WAIT || st_r == ST_STOP) && reset_req) begin
      idx_r <= IDX_RESET;
    end else if ((st_r == ST_WAIT && wait_wake) ||
                 (st_r == ST_STOP && stop_wake)) begin
      idx_r <= wake_idx;
    end
  end

  // Vector delivery in the first cycle of run, so clocks are already on.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vector_valid <= 1'b0;
      vector_addr <= vec_of(IDX_RESET);
    end else begin
      vector_valid <= 1'b0;
      if (st_r != ST_RUN && st_nxt == ST_RUN) begin
        vector_valid <= 1'b1;
        vector_addr <= (st_r == ST_WAIT)
                     ? vec_of(reset_req ? IDX_RESET : wake_idx)
                     : vec_of(idx_r);
      end
    end
  end

  // Interrupt mask: cleared by wait or an enabled stop, set by a reset wake.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      i_mask <= 1'b1;
    end else if (st_r == ST_RUN && (wait_instr || stop_go)) begin
      i_mask <= 1'b0;
    end else if (st_r != ST_RUN && reset_req) begin
      i_mask <= 1'b1;
    end
  end

  // One-cycle pulses on stop entry for converter and watchdog.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adc_abort <= 1'b0;
      cop_presc_clr <= 1'b0;
    end else begin
      adc_abort <= (st_r == ST_RUN) && !wait_instr && stop_go;
      cop_presc_clr <= (st_r == ST_RUN) && !wait_instr && stop_go;
    end
  end

  // Clock gates follow the next state so they line up with st_r.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gates <= '1; // Run state with the PLL powered, as pll_power_on_r resets high.
    end else begin
      gates.cpu_clk_en <= (st_nxt == ST_RUN);
      gates.bus_clk_en <= (st_nxt == ST_RUN) || (st_nxt == ST_WAIT)
        || (st_nxt == ST_STOP && osc_stop_en_r);
      gates.crystal_clock_en <= (st_nxt == ST_RUN) || (st_nxt == ST_WAIT)
        || (st_nxt == ST_STOP && osc_stop_en_r);
      gates.osc_enable <= !(st_nxt == ST_STOP && !osc_stop_en_r);
      gates.pll_enable <= pll_power_on_r && (st_nxt == ST_RUN || st_nxt == ST_WAIT);
      gates.bus_clock_output_en <= (st_nxt == ST_RUN) || (st_nxt == ST_WAIT)
        || (st_nxt == ST_STOP && osc_stop_en_r);
      gates.clock_gen_interrupt_en <= (st_nxt == ST_RUN)
        || (st_nxt == ST_WAIT);
      gates.adc_enable <= (st_nxt == ST_RUN || st_nxt == ST_WAIT)
        && (ch_sel_r != CH_POWER_DOWN);
      gates.brk_active <= (st_nxt == ST_RUN) || (st_nxt == ST_WAIT);
      gates.cop_clk_en <= (st_nxt == ST_RUN) || (st_nxt == ST_WAIT);
    end
  end

  // Write channel capture; address and data may arrive in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_rdy_r <= 1'b1;
      w_rdy_r <= 1'b1;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && aw_rdy_r) begin
        aw_rdy_r <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && w_rdy_r) begin
        w_rdy_r <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r == CTRL_OFF || awaddr_r == STAT_OFF)
                     ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_rdy_r <= 1'b1;
        w_rdy_r <= 1'b1;
      end
    end
  end
  assign wr_go = !aw_rdy_r && !w_rdy_r && !s_axi_bvalid;
  assign s_axi_awready = aw_rdy_r;
  assign s_axi_wready = w_rdy_r;

  // Control register; hardware forces the source select low on stop entry.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_stop_en_r <= 1'b0;
      stop_en_r <= 1'b0;
      bcs_r <= 1'b0;
      pll_power_on_r <= 1'b1;
      ch_sel_r <= CH_RESET;
    end else begin
      if (wr_go && awaddr_r == CTRL_OFF) begin
        if (wstrb_r[0]) begin
          osc_stop_en_r <= wdata_r[C_OSC];
          stop_en_r <= wdata_r[C_STOPEN];
          bcs_r <= wdata_r[C_BCS];
          pll_power_on_r <= wdata_r[C_PLL_POWER_ON];
          ch_sel_r[3:0] <= wdata_r[C_CH_LO +: 4];
        end
        if (wstrb_r[1]) begin
          ch_sel_r[4] <= wdata_r[C_CH_LO + 4];
        end
      end
      if (st_r == ST_RUN && !wait_instr && stop_go) begin
        bcs_r <= 1'b0;
      end
    end
  end

  // Break flag: write one to clear, a new break in the same cycle wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bw_r <= 1'b0;
    end else if (brk_req && (st_r == ST_WAIT || st_r == ST_STOP)) begin
      bw_r <= 1'b1;
    end else if (wr_go && awaddr_r == STAT_OFF && wstrb_r[0]
                 && wdata_r[S_BW]) begin
      bw_r <= 1'b0;
    end
  end

  // Read channel; data is taken at the address handshake.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_rdy_r <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && ar_rdy_r) begin
      ar_rdy_r <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr == CTRL_OFF) begin
        s_axi_rdata[C_OSC] <= osc_stop_en_r;
        s_axi_rdata[C_STOPEN] <= stop_en_r;
        s_axi_rdata[C_BCS] <= bcs_r;
        s_axi_rdata[C_PLL_POWER_ON] <= pll_power_on_r;
        s_axi_rdata[C_CH_LO +: CH_W] <= ch_sel_r;
      end else if (s_axi_araddr == STAT_OFF) begin
        s_axi_rdata[S_MODE_LO +: 4] <= st_r;
        s_axi_rdata[S_BW] <= bw_r;
        s_axi_rdata[S_IMASK] <= i_mask;
        s_axi_rdata[S_IDX_LO +: IDX_W] <= idx_r;
      end else begin
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      ar_rdy_r <= 1'b1;
    end
  end
  assign s_axi_arready = ar_rdy_r;

  // Checks kept beside the logic they guard.
  property p_wait_gates;
    @(posedge aclk) disable iff (!aresetn)
    st_r == ST_WAIT |-> !gates.cpu_clk_en && gates.bus_clk_en;
  endproperty
  a_wait_gates: assert property (p_wait_gates)
    else $error("wait state gate mismatch");

  property p_stop_bus;
    @(posedge aclk) disable iff (!aresetn)
    st_r == ST_STOP |-> !gates.cpu_clk_en
      && (gates.bus_clk_en == osc_stop_en_r);
  endproperty
  a_stop_bus: assert property (p_stop_bus)
    else $error("stop state bus clock mismatch");

  property p_stop_blocked;
    @(posedge aclk) disable iff (!aresetn)
    st_r == ST_RUN && stop_instr && !wait_instr && !stop_en_r
      |=> st_r == ST_RUN;
  endproperty
  a_stop_blocked: assert property (p_stop_blocked)
    else $error("stop taken while disabled");

  property p_wait_mask;
    @(posedge aclk) disable iff (!aresetn)
    st_r == ST_RUN && wait_instr |=> st_r == ST_WAIT && !i_mask;
  endproperty
  a_wait_mask: assert property (p_wait_mask)
    else $error("wait did not clear mask");

  property p_bcs_clear;
    @(posedge aclk) disable iff (!aresetn)
    st_r == ST_RUN && stop_go && !wait_instr
      |=> !bcs_r && adc_abort && cop_presc_clr && !gates.adc_enable;
  endproperty
  a_bcs_clear: assert property (p_bcs_clear)
    else $error("stop entry effects missing");

  property p_recov_hold;
    @(posedge aclk) disable iff (!aresetn)
    $rose(st_r == ST_RECOV) |-> (!gates.cpu_clk_en)[*8];
  endproperty
  a_recov_hold: assert property (p_recov_hold)
    else $error("clock released early in recovery");

  property p_cop_stop;
    @(posedge aclk) disable iff (!aresetn)
    st_r == ST_STOP |-> !gates.cop_clk_en && !gates.pll_enable;
  endproperty
  a_cop_stop: assert property (p_cop_stop)
    else $error("watchdog or pll clocked in stop");

  property p_brk_flag;
    @(posedge aclk) disable iff (!aresetn)
    st_r == ST_STOP && brk_req |=> bw_r && st_r == ST_RECOV;
  endproperty
  a_brk_flag: assert property (p_brk_flag)
    else $error("break did not wake stop");

  property p_vec_clk;
    @(posedge aclk) disable iff (!aresetn)
    vector_valid |-> gates.cpu_clk_en && st_r == ST_RUN;
  endproperty
  a_vec_clk: assert property (p_vec_clk)
    else $error("vector issued with clock off");

  property p_reset_mask;
    @(posedge aclk) disable iff (!aresetn)
    st_r == ST_WAIT && reset_req |=> i_mask && vector_valid
      && vector_addr == vec_of(IDX_RESET);
  endproperty
  a_reset_mask: assert property (p_reset_mask)
    else $error("reset wake mask or vector wrong");
endmodule : lpm_ctrl
`default_nettype wire

// ===== verif/lpm_core_model.sv
`default_nettype none
module lpm_core_model (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Commands from the bench.
  input wire logic do_wait,
  input wire logic do_stop,
  input wire logic [lpm_pkg::SLOTS-1:0] set_irq,
  input wire logic set_brk,
  input wire logic set_rst,
  // Feedback from the mode controller.
  input wire lpm_pkg::lpm_gates_s gates,
  input wire logic vector_valid,
  // Requests towards the mode controller.
  output logic wait_instr,
  output logic stop_instr,
  output logic [lpm_pkg::SLOTS-1:0] irq_req,
  output logic brk_req,
  output logic reset_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import lpm_pkg::*;

  // A halted core executes nothing, so instructions need its clock.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_instr <= 1'b0;
      stop_instr <= 1'b0;
    end else begin
      wait_instr <= do_wait & gates.cpu_clk_en;
      stop_instr <= do_stop & gates.cpu_clk_en;
    end
  end

  // Sources hold their requests until a vector is fetched; one fetch
  // retires every pending source, simpler than a per-source acknowledge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req <= '0;
      brk_req <= 1'b0;
      reset_req <= 1'b0;
    end else if (vector_valid) begin
      irq_req <= '0;
      brk_req <= 1'b0;
      reset_req <= 1'b0;
    end else begin
      irq_req <= irq_req | set_irq;
      brk_req <= brk_req | set_brk;
      reset_req <= reset_req | set_rst;
    end
  end
endmodule : lpm_core_model
`default_nettype wire

// ===== verif/test_low_power_mode_control.sv
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_low_power_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  import lpm_pkg::*;
  localparam int RT = 8;
  localparam int XD = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic do_wait = 1'b0, do_stop = 1'b0, set_brk = 1'b0, set_rst = 1'b0;
  logic [SLOTS-1:0] set_irq = '0, irq_req;
  logic wait_instr, stop_instr, brk_req, reset_req;
  lpm_gates_s gates;
  logic adc_abort, cop_presc_clr, i_mask, vector_valid;
  logic [15:0] vector_addr;
  int errors = 0, cmp_count = 0, cyc = 0;

  lpm_ctrl #(.XTAL_DIV(XD), .RECOVERY_TICKS(RT)) u_lpm_ctrl (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .wait_instr(wait_instr), .stop_instr(stop_instr),
    .reset_req(reset_req), .brk_req(brk_req), .irq_req(irq_req),
    .gates(gates), .adc_abort(adc_abort), .cop_presc_clr(cop_presc_clr),
    .i_mask(i_mask), .vector_addr(vector_addr),
    .vector_valid(vector_valid));

  lpm_core_model u_lpm_core_model (
    .aclk(aclk), .aresetn(aresetn), .do_wait(do_wait),
    .do_stop(do_stop), .set_irq(set_irq), .set_brk(set_brk),
    .set_rst(set_rst), .gates(gates), .vector_valid(vector_valid),
    .wait_instr(wait_instr), .stop_instr(stop_instr),
    .irq_req(irq_req), .brk_req(brk_req), .reset_req(reset_req));

  // Free-running bus clock.
  always #5 aclk = ~aclk;

  task automatic end_sim();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // A hang anywhere ends the run as a failure.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end

  // Handshakes are judged just after an edge, where registered outputs
  // already show what the next edge will sample.
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic ta, tw, tb;
    int k;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    k = 0;
    while (!tb && k < 50) begin
      #1;
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      k++;
    end
    bready <= 1'b0;
    if (!tb) errors++;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic ta, tr;
    int k;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    tr = 1'b0;
    k = 0;
    while (!tr && k < 50) begin
      #1;
      ta = arvalid && arready;
      tr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      k++;
    end
    rready <= 1'b0;
    if (!tr) errors++;
  endtask : axr

  task automatic instr(input logic w, input logic s);
    @(posedge aclk); do_wait <= w; do_stop <= s;
    @(posedge aclk); do_wait <= 1'b0; do_stop <= 1'b0;
    @(posedge aclk); #1;
  endtask : instr

  task automatic req(input logic [SLOTS-1:0] i, input logic b, r);
    @(posedge aclk); set_irq <= i; set_brk <= b; set_rst <= r;
    @(posedge aclk); set_irq <= '0; set_brk <= 1'b0; set_rst <= 1'b0;
  endtask : req

  // Enter wait or stop, offer non-waking sources, then wake and check.
  task automatic go(input logic s, input logic [SLOTS-1:0] pre, irq,
                    input logic b, r, input logic [15:0] ev,
                    input logic em, input logic [9:0] gm, gv);
    int k;
    logic held;
    instr(!s, s);
    `CHK(gates & gm, gv)
    `CHK(i_mask, 1'b0)
    `CHK({adc_abort, cop_presc_clr}, {s, s})
    if (pre != '0) begin
      req(pre, 1'b0, 1'b0);
      repeat (6) begin
        @(posedge aclk); #1;
        `CHK(vector_valid, 1'b0)
      end
    end
    req(irq, b, r);
    k = 0;
    held = 1'b1;
    do begin
      @(posedge aclk); #1;
      k++;
      if (vector_valid !== 1'b1) held = held & ~gates.cpu_clk_en;
    end while (vector_valid !== 1'b1 && k < 200);
    `CHK(vector_addr, ev)
    if (s) `CHK(k >= RT*XD && k <= RT*XD+XD+4, 1'b1)
    else `CHK(k == 1, 1'b1)
    `CHK(held, 1'b1)
    @(posedge aclk); #1;
    `CHK(i_mask, em)
    `CHK(gates.cpu_clk_en, 1'b1)
  endtask : go

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    `CHK(gates, 10'h3ff)
    `CHK({i_mask, vector_valid, vector_addr}, {2'b10, 16'hfffe})
    axr(CTRL_OFF, rd, rs);
    `CHK({rs, rd}, {RESP_OKAY, 32'h8})
    axr(STAT_OFF, rd, rs);
    `CHK(rd[5:0], 6'h21)
    axr(8'h08, rd, rs);
    `CHK({rs, rd}, {RESP_SLVERR, 32'h0})
    axw(8'h0c, 32'hff, rs);
    `CHK(rs, RESP_SLVERR)
    // Stop is refused while its enable bit is clear.
    instr(1'b0, 1'b1);
    `CHK(gates.cpu_clk_en, 1'b1)
    axr(STAT_OFF, rd, rs);
    `CHK(rd[3:0], 4'h1)
    // Every interrupt slot 0 to 16 but reserved slot 9 wakes wait with its own vector.
    for (int s = 0; s < 17; s++) begin
      if (s != 9) go(0, '0, SLOTS'(1) << s, 0, 0, VEC_BASE + 16'(2 * s),
                     0, 10'h3ff, 10'h1ff);
    end
    go(0, 18'h200, 18'h1008, 0, 0, 16'hfff4, 0, 10'h3ff, 10'h1ff);
    go(0, '0, 18'h8000, 1, 0, 16'hfffc, 0, 10'h3ff, 10'h1ff);
    axr(STAT_OFF, rd, rs);
    `CHK(rd[4], 1'b1)
    axw(STAT_OFF, 32'h10, rs);
    axr(STAT_OFF, rd, rs);
    `CHK(rd[4], 1'b0)
    go(0, '0, '0, 1, 1, 16'hfffe, 1, 10'h3ff, 10'h1ff);
    // Converter and PLL powered down by software before wait.
    axw(CTRL_OFF, 32'h1f0, rs);
    go(0, '0, 18'h2, 0, 0, 16'hffde, 0, 10'h3ff, 10'h1db);
    axw(CTRL_OFF, 32'he, rs);
    go(1, 18'h3, 18'h8000, 0, 0, 16'hfffa, 0, 10'h3ff, 10'h0);
    // Software lets the converter settle before it trusts any result.
    repeat (XD) @(posedge aclk);
    #1;
    `CHK(gates.adc_enable, 1'b1)
    axr(CTRL_OFF, rd, rs);
    `CHK(rd[8:0], 9'h00a)
    axw(CTRL_OFF, 32'hb, rs);
    go(1, '0, 18'h1, 0, 0, 16'hffdc, 0, 10'h267, 10'h040);
    go(1, '0, 18'h4, 0, 0, 16'hffe0, 0, 10'h267, 10'h040);
    // Clear the flag first, so only the break out of stop can set it.
    axw(STAT_OFF, 32'h10, rs);
    `CHK(rs, RESP_OKAY)
    go(1, '0, '0, 1, 0, 16'hfffc, 0, 10'h267, 10'h040);
    axr(STAT_OFF, rd, rs);
    `CHK(rd[4], 1'b1)
    go(1, '0, '0, 0, 1, 16'hfffe, 1, 10'h267, 10'h040);
    end_sim();
  end
endmodule : test_low_power_mode_control
`default_nettype wire
